// File: acs_sequencer.sv
`timescale 1ns/1ps
`include "acs_cfg.svh"

module acs_sequencer
  import acs_pkg::*;
(
  // Clock and reset
  input wire logic MCLK,
  input wire logic SYS_RST,
  // Register port
  input wire logic [3:0] REG_ADDR,
  input wire logic [15:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [15:0] REG_RDATA,
  // Capture/compare injection trigger
  input wire logic CC_TRIG,
  // Analog core
  output logic [3:0] ANA_CH,
  output logic ANA_EXT,
  output logic ANA_SAMPLE,
  output logic ANA_CONVERT,
  input wire logic [9:0] ANA_RESULT,
  // Requests and status
  output logic EOC_REQ,
  output logic ERR_REQ,
  output logic BUSY
);

  acs_state_s s_r;
  acs_state_s s_nxt;
  logic go_rise;
  logic rq_rise;
  logic done;
  logic park;
  logic [10:0] bc_div;
  logic [10:0] samp_cyc;
  logic [10:0] conv_cyc;

  // ****************************************
  // Timing selection
  // ****************************************
  function automatic logic [10:0] div_of(input logic [1:0] code);
    case (code)
      2'b00: div_of = `ACS_DIV_00;
      2'b01: div_of = `ACS_DIV_01;
      2'b10: div_of = `ACS_DIV_10;
      default: div_of = `ACS_DIV_11;
    endcase
  endfunction : div_of

  function automatic logic [10:0] stc_of(input logic [1:0] code);
    case (code)
      2'b00: stc_of = `ACS_STC_00;
      2'b01: stc_of = `ACS_STC_01;
      2'b10: stc_of = `ACS_STC_10;
      default: stc_of = `ACS_STC_11;
    endcase
  endfunction : stc_of

  function automatic logic [15:0] pack_res(input acs_res_s r);
    pack_res = `ACS_RST_WORD;
    pack_res[`ACS_F_RCH] = r.ch;
    pack_res[`ACS_B_RX] = r.ext;
    pack_res[`ACS_F_RVAL] = r.val;
  endfunction : pack_res

  assign bc_div = div_of(s_r.ctl.ctc);
  assign samp_cyc = 11'(bc_div * stc_of(s_r.ctl.stc));
  assign conv_cyc = 11'(bc_div * `ACS_CONV_TBC);
  assign go_rise = s_r.ctl.go & ~s_r.go_prev;
  assign rq_rise = s_r.ctl.injrq & ~s_r.rq_prev;
  assign done = (s_r.phase == ACS_XFER) && (s_r.cnt == '0);
  assign park = s_r.ctl.hold & s_r.res_unread;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    s_nxt = s_r;
    s_nxt.go_prev = s_r.ctl.go;
    s_nxt.rq_prev = s_r.ctl.injrq;
    s_nxt.rdata = `ACS_RST_WORD;

    // Phase timer: sample, steps, transfer
    case (s_r.phase)
      ACS_SAMPLE: begin
        if (s_r.cnt == '0) begin
          s_nxt.phase = ACS_CONV;
          s_nxt.cnt = conv_cyc - `ACS_ONE;
        end else begin
          s_nxt.cnt = s_r.cnt - `ACS_ONE;
        end
      end
      ACS_CONV: begin
        if (s_r.cnt == '0) begin
          s_nxt.phase = ACS_XFER;
          s_nxt.cnt = `ACS_XFER_CYC - `ACS_ONE;
          s_nxt.conv_val = ANA_RESULT;
        end else begin
          s_nxt.cnt = s_r.cnt - `ACS_ONE;
        end
      end
      ACS_XFER: begin
        if (s_r.cnt == '0) begin
          s_nxt.phase = ACS_IDLE;
        end else begin
          s_nxt.cnt = s_r.cnt - `ACS_ONE;
        end
      end
      ACS_IDLE: begin
      end
      default: s_nxt.phase = ACS_IDLE;
    endcase

    // Injected channel follows the register live, so a write while sampling moves the mux
    if (s_r.cur_inj && s_r.phase != ACS_IDLE) begin
      s_nxt.cur_ch = s_r.inj.ch;
      s_nxt.cur_x = s_r.inj.ext;
    end

    // Reads clear unread state before any load this cycle, so a load wins
    if (REG_RD && REG_ADDR == `ACS_ADDR_RES) begin
      if (s_r.buf_vld && !s_r.buf_inj) begin
        s_nxt.res = s_r.buff;
        s_nxt.res_unread = 1'b1;
        s_nxt.eoc = 1'b1;
        s_nxt.buf_vld = 1'b0;
        if (!s_r.run) begin
          s_nxt.ctl.go = 1'b0;
        end
      end else begin
        s_nxt.res_unread = 1'b0;
      end
    end
    if (REG_RD && REG_ADDR == `ACS_ADDR_INJ) begin
      if (s_r.buf_vld && s_r.buf_inj) begin
        s_nxt.inj.val = s_r.buff.val;
        s_nxt.inj_unread = 1'b1;
        s_nxt.err = 1'b1;
        s_nxt.buf_vld = 1'b0;
      end else begin
        s_nxt.inj_unread = 1'b0;
      end
    end

    // Flag clear by writing one; a same-cycle set below still wins
    if (REG_WR && REG_ADDR == `ACS_ADDR_STS) begin
      if (REG_WDATA[`ACS_B_EOC]) begin
        s_nxt.eoc = 1'b0;
      end
      if (REG_WDATA[`ACS_B_ERR]) begin
        s_nxt.err = 1'b0;
      end
    end

    // Completion of a conversion
    if (done) begin
      if (s_r.cur_inj) begin
        if (s_r.inj_unread) begin
          s_nxt.buff = '{ch: s_r.cur_ch, ext: s_r.cur_x, val: s_r.conv_val};
          s_nxt.buf_vld = 1'b1;
          s_nxt.buf_inj = 1'b1;
        end else begin
          s_nxt.inj.val = s_r.conv_val;
          s_nxt.inj_unread = 1'b1;
          s_nxt.err = 1'b1;
        end
        s_nxt.cur_inj = 1'b0;
      end else begin
        if (park) begin
          s_nxt.buff = '{ch: s_r.cur_ch, ext: s_r.cur_x, val: s_r.conv_val};
          s_nxt.buf_vld = 1'b1;
          s_nxt.buf_inj = 1'b0;
        end else begin
          s_nxt.res = '{ch: s_r.cur_ch, ext: s_r.cur_x, val: s_r.conv_val};
          s_nxt.res_unread = 1'b1;
          s_nxt.eoc = 1'b1;
          if (s_r.res_unread) begin
            s_nxt.err = 1'b1;
          end
        end
        if (s_r.ctl.mode[`ACS_B_AUTO] && s_r.cur_ch != '0) begin
          s_nxt.nch = s_r.cur_ch - 4'h1;
          s_nxt.nx = s_r.cur_x;
        end else if (s_r.ctl.mode[`ACS_B_CONT] && s_r.ctl.go) begin
          s_nxt.nch = s_r.ctl.ch;
          s_nxt.nx = s_r.ctl.ext;
        end else begin
          s_nxt.run = 1'b0;
          if (!s_r.ctl.mode[`ACS_B_CONT] && !park) begin
            s_nxt.ctl.go = 1'b0;
          end
        end
      end
    end

    // Software control writes; busy is read-only
    if (REG_WR && REG_ADDR == `ACS_ADDR_CTL) begin
      s_nxt.ctl.ch = REG_WDATA[`ACS_F_CH];
      s_nxt.ctl.mode = REG_WDATA[`ACS_F_MODE];
      s_nxt.ctl.ext = REG_WDATA[`ACS_B_EXT];
      s_nxt.ctl.go = REG_WDATA[`ACS_B_GO];
      s_nxt.ctl.hold = REG_WDATA[`ACS_B_HOLD];
      s_nxt.ctl.injen = REG_WDATA[`ACS_B_INJEN];
      s_nxt.ctl.injrq = REG_WDATA[`ACS_B_INJRQ];
      s_nxt.ctl.stc = REG_WDATA[`ACS_F_STC];
      s_nxt.ctl.ctc = REG_WDATA[`ACS_F_CTC];
    end
    if (REG_WR && REG_ADDR == `ACS_ADDR_INJ) begin
      s_nxt.inj.ch = REG_WDATA[`ACS_F_RCH];
      s_nxt.inj.ext = REG_WDATA[`ACS_B_RX];
    end

    // Arbitration of new requests
    if (go_rise) begin
      s_nxt.run = 1'b1;
      s_nxt.nch = s_r.ctl.ch;
      s_nxt.nx = s_r.ctl.ext;
      if (s_r.phase != ACS_IDLE && !s_r.cur_inj && !done) begin
        s_nxt.phase = ACS_IDLE;
      end
    end
    if (rq_rise && s_r.ctl.injen && s_r.ctl.hold) begin
      s_nxt.inj_pend = 1'b1;
    end

    // Start when idle and the temporary buffer is empty; injection goes first
    if (s_nxt.phase == ACS_IDLE && !s_nxt.buf_vld) begin
      if (s_nxt.inj_pend) begin
        s_nxt.inj_pend = 1'b0;
        s_nxt.cur_inj = 1'b1;
        s_nxt.cur_ch = s_nxt.inj.ch;
        s_nxt.cur_x = s_nxt.inj.ext;
        s_nxt.ctl.injrq = 1'b0;
        s_nxt.phase = ACS_SAMPLE;
        s_nxt.cnt = samp_cyc - `ACS_ONE;
      end else if (s_nxt.run) begin
        s_nxt.cur_inj = 1'b0;
        s_nxt.cur_ch = s_nxt.nch;
        s_nxt.cur_x = s_nxt.nx;
        s_nxt.phase = ACS_SAMPLE;
        s_nxt.cnt = samp_cyc - `ACS_ONE;
      end
    end
    if (CC_TRIG) begin
      s_nxt.ctl.injrq = 1'b1;
    end
    s_nxt.busy = s_nxt.run | s_nxt.buf_vld | (s_nxt.phase != ACS_IDLE);

    // Read data, valid only in the cycle after the strobe
    if (REG_RD) begin
      case (REG_ADDR)
        `ACS_ADDR_CTL: begin
          s_nxt.rdata[`ACS_F_CH] = s_r.ctl.ch;
          s_nxt.rdata[`ACS_F_MODE] = s_r.ctl.mode;
          s_nxt.rdata[`ACS_B_EXT] = s_r.ctl.ext;
          s_nxt.rdata[`ACS_B_GO] = s_r.ctl.go;
          s_nxt.rdata[`ACS_B_BUSY] = s_r.busy;
          s_nxt.rdata[`ACS_B_HOLD] = s_r.ctl.hold;
          s_nxt.rdata[`ACS_B_INJEN] = s_r.ctl.injen;
          s_nxt.rdata[`ACS_B_INJRQ] = s_r.ctl.injrq;
          s_nxt.rdata[`ACS_F_STC] = s_r.ctl.stc;
          s_nxt.rdata[`ACS_F_CTC] = s_r.ctl.ctc;
        end
        `ACS_ADDR_RES: s_nxt.rdata = pack_res(s_r.res);
        `ACS_ADDR_INJ: s_nxt.rdata = pack_res(s_r.inj);
        `ACS_ADDR_STS: begin
          s_nxt.rdata[`ACS_B_EOC] = s_r.eoc;
          s_nxt.rdata[`ACS_B_ERR] = s_r.err;
        end
        default: s_nxt.rdata = `ACS_RST_WORD;
      endcase
    end
  end

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign REG_RDATA = s_r.rdata;
  assign ANA_CH = s_r.cur_ch;
  assign ANA_EXT = s_r.cur_x;
  assign ANA_SAMPLE = (s_r.phase == ACS_SAMPLE);
  assign ANA_CONVERT = (s_r.phase == ACS_CONV);
  assign EOC_REQ = s_r.eoc;
  assign ERR_REQ = s_r.err;
  assign BUSY = s_r.busy;

  // ****************************************
  // Assertions
  // ****************************************
  logic [10:0] samp_len_r;

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      samp_len_r <= '0;
    end else if (go_rise && !s_r.cur_inj) begin
      samp_len_r <= '0;
    end else if (s_r.phase == ACS_SAMPLE) begin
      samp_len_r <= samp_len_r + `ACS_ONE;
    end else begin
      samp_len_r <= '0;
    end
  end

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (SYS_RST);

  sequence s_std_done;
    done && !s_r.cur_inj;
  endsequence

  sequence s_quiet;
    !REG_WR && !REG_RD && !go_rise && !rq_rise && !s_r.inj_pend && !CC_TRIG;
  endsequence

  a_sample_length: assert property (
    (s_r.phase == ACS_CONV) && ($past(s_r.phase) == ACS_SAMPLE) |-> samp_len_r == $past(samp_cyc))
    else $error("sample phase length does not match selection");

  a_xfer_two: assert property (
    $rose(s_r.phase == ACS_XFER) ##1 (s_r.phase == ACS_XFER) |=> s_r.phase != ACS_XFER)
    else $error("transfer phase longer than two cycles");

  a_eoc_raise: assert property (
    s_std_done ##0 !park |=> EOC_REQ && s_r.res_unread)
    else $error("end of conversion not raised");

  a_overrun_flag: assert property (
    s_std_done ##0 (!s_r.ctl.hold && s_r.res_unread) |=> ERR_REQ)
    else $error("overrun not flagged");

  a_park_hold: assert property (
    s_std_done ##0 park ##0 s_quiet |=> s_r.buf_vld && BUSY && s_r.phase == ACS_IDLE)
    else $error("result not parked");

  a_release_read: assert property (
    REG_RD && REG_ADDR == `ACS_ADDR_RES && s_r.buf_vld && !s_r.buf_inj
    |=> EOC_REQ && !s_r.buf_vld && (s_r.phase == ACS_SAMPLE || !s_r.run))
    else $error("parked result not released");

  a_single_stop: assert property (
    s_std_done ##0 (s_r.ctl.mode == `ACS_MODE_FSINGLE && !park) ##0 s_quiet
    |=> !BUSY && !s_r.ctl.go)
    else $error("single conversion did not stop");

  a_scan_down: assert property (
    s_std_done ##0 (s_r.ctl.mode[`ACS_B_AUTO] && s_r.cur_ch != '0 && !park) ##0 s_quiet
    |=> s_r.phase == ACS_SAMPLE && s_r.cur_ch == $past(s_r.cur_ch) - 4'h1)
    else $error("scan did not step to next lower channel");

  a_trig_sets: assert property (
    CC_TRIG |=> s_r.ctl.injrq)
    else $error("trigger did not set injection request");

  a_inj_start: assert property (
    rq_rise && s_r.ctl.injen && s_r.ctl.hold && s_r.phase == ACS_IDLE && !s_r.buf_vld
    && !CC_TRIG && !REG_WR |=> s_r.cur_inj && s_r.phase == ACS_SAMPLE && !s_r.ctl.injrq)
    else $error("idle injection did not start");

  a_std_abort: assert property (
    go_rise && s_r.phase != ACS_IDLE && !s_r.cur_inj && !done && !s_r.buf_vld
    && !s_r.inj_pend && !rq_rise
    |=> s_r.phase == ACS_SAMPLE && !s_r.cur_inj && s_r.cnt == $past(samp_cyc) - `ACS_ONE)
    else $error("standard request did not restart conversion");

endmodule : acs_sequencer

// File: acs_cfg.svh
`ifndef ACS_CFG_SVH
`define ACS_CFG_SVH

// ****************************************
// Register addresses
// ****************************************
`define ACS_ADDR_CTL 4'h0
`define ACS_ADDR_RES 4'h1
`define ACS_ADDR_INJ 4'h2
`define ACS_ADDR_STS 4'h3

// ****************************************
// Field positions
// ****************************************
`define ACS_F_CH 3:0
`define ACS_F_MODE 5:4
`define ACS_B_EXT 6
`define ACS_B_GO 7
`define ACS_B_BUSY 8
`define ACS_B_HOLD 9
`define ACS_B_INJEN 10
`define ACS_B_INJRQ 11
`define ACS_F_STC 13:12
`define ACS_F_CTC 15:14
`define ACS_F_RCH 15:12
`define ACS_B_RX 11
`define ACS_F_RVAL 9:0
`define ACS_B_EOC 0
`define ACS_B_ERR 1
`define ACS_B_AUTO 1
`define ACS_B_CONT 0
`define ACS_MODE_FSINGLE 2'b00

// ****************************************
// Reset values and timing counts (dividers and transfer in MCLK cycles, sample and conversion in divided clock periods)
// ****************************************
`define ACS_RST_WORD 16'h0000
`define ACS_DIV_00 11'h004
`define ACS_DIV_01 11'h002
`define ACS_DIV_10 11'h010
`define ACS_DIV_11 11'h008
`define ACS_STC_00 11'h008
`define ACS_STC_01 11'h010
`define ACS_STC_10 11'h020
`define ACS_STC_11 11'h040
`define ACS_CONV_TBC 11'h028
`define ACS_XFER_CYC 11'h002
`define ACS_ONE 11'h001

`endif

// File: acs_pkg.sv
package acs_pkg;

  typedef enum logic [1:0] {
    ACS_IDLE = 2'b00,
    ACS_SAMPLE = 2'b01,
    ACS_CONV = 2'b10,
    ACS_XFER = 2'b11
  } acs_phase_e;

  typedef struct packed {
    logic [1:0] ctc;
    logic [1:0] stc;
    logic injrq;
    logic injen;
    logic hold;
    logic go;
    logic ext;
    logic [1:0] mode;
    logic [3:0] ch;
  } acs_ctl_s;

  typedef struct packed {
    logic [3:0] ch;
    logic ext;
    logic [9:0] val;
  } acs_res_s;

  typedef struct packed {
    acs_ctl_s ctl;
    acs_res_s res;
    acs_res_s inj;
    acs_res_s buff;
    logic buf_vld;
    logic buf_inj;
    logic res_unread;
    logic inj_unread;
    logic eoc;
    logic err;
    logic busy;
    acs_phase_e phase;
    logic [10:0] cnt;
    logic run;
    logic [3:0] nch;
    logic nx;
    logic inj_pend;
    logic cur_inj;
    logic [3:0] cur_ch;
    logic cur_x;
    logic [9:0] conv_val;
    logic go_prev;
    logic rq_prev;
    logic [15:0] rdata;
  } acs_state_s;

endpackage : acs_pkg

// File: acs_analog_model.sv
`timescale 1ns/1ps

// ****************************************
// Analog core stand-in
// ****************************************
module acs_analog_model (
  // Clock
  input wire logic mclk,
  // Mux and phase control
  input wire logic [3:0] ana_ch,
  input wire logic ana_ext,
  input wire logic ana_sample,
  input wire logic ana_convert,
  // Conversion value
  output logic [9:0] ana_result
);
  logic [9:0] held_r = 10'h000;
  logic [9:0] idle_r = 10'h155;

  // Mux is followed live while sampling, so a late channel change is seen
  always_ff @(posedge mclk) begin
    if (ana_sample) begin
      held_r <= {ana_ext, ana_ch, 5'h15};
    end
    idle_r <= ~idle_r;
  end

  // Outside the conversion steps the value is junk that moves every cycle
  assign ana_result = ana_convert ? held_r : idle_r;
endmodule : acs_analog_model

// File: test_adc_conversion_sequencer.sv
`timescale 1ns/1ps
`include "acs_cfg.svh"

module test_adc_conversion_sequencer;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic cc_trig = 1'b0;
  logic [15:0] reg_rdata;
  logic [3:0] ana_ch;
  logic ana_ext, ana_sample, ana_convert, eoc_req, err_req, busy;
  logic [9:0] ana_result;
  logic [2:0] flags;
  logic [15:0] d;
  int fail_count = 0;
  int comparisons = 0;
  int n, ns, nc;
  int divs[4] = '{4, 2, 16, 8};
  int samps[4] = '{8, 16, 32, 64};

  assign flags = {busy, err_req, eoc_req};

  always #10 mclk = ~mclk;

  acs_sequencer i_dut (.MCLK(mclk), .SYS_RST(sys_rst), .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
    .CC_TRIG(cc_trig), .ANA_CH(ana_ch), .ANA_EXT(ana_ext), .ANA_SAMPLE(ana_sample),
    .ANA_CONVERT(ana_convert), .ANA_RESULT(ana_result), .EOC_REQ(eoc_req),
    .ERR_REQ(err_req), .BUSY(busy));

  acs_analog_model i_core (.mclk(mclk), .ana_ch(ana_ch), .ana_ext(ana_ext),
    .ana_sample(ana_sample), .ana_convert(ana_convert), .ana_result(ana_result));

  // ****************************************
  // Bus and check helpers
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Returns just past the taking edge so flag updates have landed
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge mclk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask : rd

  task automatic trig;
    @(posedge mclk);
    cc_trig <= 1'b1;
    @(posedge mclk);
    cc_trig <= 1'b0;
  endtask : trig

  // Flag index: 0 end of conversion, 1 error, 2 busy
  task automatic wait_flag(input int idx, input logic lvl);
    int k;
    k = 0;
    while (flags[idx] !== lvl && k < 4000) begin
      @(posedge mclk);
      #1;
      k++;
    end
    if (k >= 4000) begin
      fail_count++;
    end
  endtask : wait_flag

  // Counts cycles after the last write until the end-of-conversion request
  // Sampling starts on the first counted edge; the two transfer cycles and the flag register add three
  task automatic run_wait(output int t, output int s, output int c);
    t = 0;
    s = 0;
    c = 0;
    while (eoc_req !== 1'b1 && t < 4000) begin
      @(posedge mclk);
      #1;
      t++;
      s += int'(ana_sample === 1'b1);
      c += int'(ana_convert === 1'b1);
    end
  endtask : run_wait

  function automatic logic [15:0] exp_word(input logic [3:0] ch, input logic x);
    return {ch, x, 1'b0, x, ch, 5'h15};
  endfunction : exp_word

  task automatic expect_res(input logic [3:0] ch, input logic x);
    wait_flag(0, 1'b1);
    rd(`ACS_ADDR_RES, d);
    check(d, exp_word(ch, x));
    wr(`ACS_ADDR_STS, 16'h0003);
  endtask : expect_res

  task automatic final_report;
    $display("comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : final_report

  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    repeat (5) @(posedge mclk);
    sys_rst <= 1'b0;
    for (int a = 0; a < 5; a++) begin
      rd(a[3:0], d);
      check(d, 32'h0);
    end
    // Every clock and sample code, single fixed conversion
    for (int i = 0; i < 4; i++) begin
      wr(`ACS_ADDR_CTL, {i[1:0], i[1:0], 8'h08, i[3:0] + 4'h3});
      run_wait(n, ns, nc);
      check(ns, divs[i] * samps[i]);
      check(nc, divs[i] * 40);
      check(n, divs[i] * (samps[i] + 40) + 3);
      check(busy, 1'b0);
      rd(`ACS_ADDR_CTL, d);
      check(d[8:7], 2'b00);
      expect_res(i[3:0] + 4'h3, 1'b0);
    end
    // Continuous without wait-for-read: overrun, then stop
    wr(`ACS_ADDR_CTL, 16'h4092);
    expect_res(4'h2, 1'b0);
    wait_flag(0, 1'b1);
    wr(`ACS_ADDR_STS, 16'h0003);
    wait_flag(0, 1'b1);
    check(err_req, 1'b1);
    check(busy, 1'b1);
    wr(`ACS_ADDR_STS, 16'h0003);
    wr(`ACS_ADDR_CTL, 16'h4012);
    check(busy, 1'b1);
    wait_flag(2, 1'b0);
    check(eoc_req, 1'b1);
    expect_res(4'h2, 1'b0);
    // Single scan of the extension group
    wr(`ACS_ADDR_CTL, 16'h40E2);
    for (int c = 2; c >= 0; c--) begin
      expect_res(c[3:0], 1'b1);
    end
    wait_flag(2, 1'b0);
    rd(`ACS_ADDR_CTL, d);
    check(d[8:7], 2'b00);
    // Continuous scan, stopped in mid-sequence
    wr(`ACS_ADDR_CTL, 16'h40B1);
    expect_res(4'h1, 1'b0);
    expect_res(4'h0, 1'b0);
    expect_res(4'h1, 1'b0);
    wr(`ACS_ADDR_CTL, 16'h4031);
    check(busy, 1'b1);
    expect_res(4'h0, 1'b0);
    wait_flag(2, 1'b0);
    repeat (10) @(posedge mclk);
    check(ana_sample, 1'b0);
    // Wait-for-read parks the second result
    wr(`ACS_ADDR_CTL, 16'h4293);
    wait_flag(0, 1'b1);
    wr(`ACS_ADDR_STS, 16'h0003);
    repeat (300) @(posedge mclk);
    check({eoc_req, err_req}, 2'b00);
    check({busy, ana_sample, ana_convert}, 3'b100);
    rd(`ACS_ADDR_RES, d);
    check(d, exp_word(4'h3, 1'b0));
    check(eoc_req, 1'b1);
    rd(`ACS_ADDR_RES, d);
    check(d, exp_word(4'h3, 1'b0));
    wr(`ACS_ADDR_STS, 16'h0003);
    wr(`ACS_ADDR_CTL, 16'h4213);
    wait_flag(2, 1'b0);
    check(eoc_req, 1'b1);
    expect_res(4'h3, 1'b0);
    // Injection: trigger sets the request even while disabled
    wr(`ACS_ADDR_INJ, 16'h7000);
    trig();
    rd(`ACS_ADDR_CTL, d);
    check(d[11], 1'b1);
    // Stale request cleared before enabling
    wr(`ACS_ADDR_CTL, 16'h4200);
    wr(`ACS_ADDR_CTL, 16'h4684);
    repeat (20) @(posedge mclk);
    trig();
    expect_res(4'h4, 1'b0);
    wait_flag(1, 1'b1);
    check(err_req, 1'b1);
    rd(`ACS_ADDR_INJ, d);
    check(d, exp_word(4'h7, 1'b0));
    rd(`ACS_ADDR_CTL, d);
    check(d[11], 1'b0);
    wr(`ACS_ADDR_STS, 16'h0003);
    // Injection requested while idle starts at once
    trig();
    @(posedge mclk);
    #1;
    check({ana_sample, ana_ch}, 5'h17);
    wait_flag(1, 1'b1);
    rd(`ACS_ADDR_INJ, d);
    check(d, exp_word(4'h7, 1'b0));
    wr(`ACS_ADDR_STS, 16'h0003);
    // Standard restart aborts the running standard conversion
    wr(`ACS_ADDR_CTL, 16'h4085);
    repeat (30) @(posedge mclk);
    wr(`ACS_ADDR_CTL, 16'h4005);
    wr(`ACS_ADDR_CTL, 16'h4085);
    run_wait(n, ns, nc);
    check(n, 2 * (8 + 40) + 3);
    expect_res(4'h5, 1'b0);
    final_report();
  end

  // Whole run needs well under a tenth of this span
  initial begin
    #1_500_000;
    fail_count++;
    final_report();
  end
endmodule : test_adc_conversion_sequencer
